// file: crpc_core_regulator_powerup_control.sv
// core regulator power-up control: combines wake requests into regulator enable
//
// Behaviour
// - external power-up pin low turns the regulator on whenever the supply is up
// - jtag test reset held high keeps the regulator on
// - fabric request low turns off only with pin high and trst low
// - initial-state bit decides regulator on or off when 3.3 V arrives
// - a zero-to-one step on the counter match input turns the regulator on
// - core good is high while the core is powered and working
// - core power-up output is the inverse of the external pin level
// - regulator enable one turns the 1.5 V regulator on, zero off
// - undriven external power-up pin reads high through a weak pull-up
`timescale 1ns/1ps
module crpc_core_regulator_powerup_control
  import crpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ext_powerup_n,
  input wire logic ext_powerup_oe,
  input wire logic jtag_trst,
  input wire logic fabric_powerup_req,
  input wire logic regulator_initial_state,
  input wire logic counter_match_wake,
  input wire logic supply_up,
  output logic regulator_enable,
  output logic core_powerup_out,
  output logic core_good
);

  logic ext_level;
  logic ext_req;
  logic trst_req;
  logic fabric_req;
  logic supply_rise;
  logic fabric_fall;
  logic latch_clear;
  logic match_rise;
  logic wake_q;

  logic supply_prev_reg;
  logic supply_prev_next;
  logic fabric_prev_reg;
  logic fabric_prev_next;
  logic init_req_reg;
  logic init_req_next;
  logic regulator_enable_reg;
  logic regulator_enable_next;
  logic core_good_reg;
  logic core_good_next;
  logic core_powerup_reg;
  logic core_powerup_next;

  // pin level with the weak pull-up when nobody drives it
  assign ext_level = ext_powerup_oe ? ext_powerup_n : PIN_PULLUP_LEVEL;

  // decoded request levels
  assign ext_req = (ext_level == EXT_PWRUP_ACTIVE);
  assign trst_req = (jtag_trst == TRST_PWRUP_ACTIVE);
  assign fabric_req = (fabric_powerup_req == FABRIC_PWRUP_ACTIVE);

  // edges of the supply and of the fabric request
  assign supply_rise = supply_up & ~supply_prev_reg;
  assign fabric_fall = fabric_prev_reg & ~fabric_req;
  // latched requests drop when the fabric asks for power-down or supply goes
  assign latch_clear = fabric_fall | ~supply_up;

  // counter match edge catcher and wake latch
  crpc_wake_latch u_wake (
    .ref_clk(ref_clk),
    .reset(reset),
    .match_in(counter_match_wake),
    .clear(latch_clear),
    .rise(match_rise),
    .wake_q(wake_q)
  );

  // initial-state request caught at supply arrival, set wins over clear
  always_comb begin
    supply_prev_next = supply_up;
    fabric_prev_next = fabric_req;
    if (supply_rise) begin
      init_req_next = (regulator_initial_state == INIT_STATE_ON);
    end else if (latch_clear) begin
      init_req_next = 1'b0;
    end else begin
      init_req_next = init_req_reg;
    end
  end

  // request registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      supply_prev_reg <= SUPPLY_PREV_RST;
      fabric_prev_reg <= FABRIC_PREV_RST;
      init_req_reg <= INIT_REQ_RST;
    end else begin
      supply_prev_reg <= supply_prev_next;
      fabric_prev_reg <= fabric_prev_next;
      init_req_reg <= init_req_next;
    end
  end

  // regulator enable as the OR of every live request, only with supply
  always_comb begin
    regulator_enable_next = 1'b0;
    if (supply_up) begin
      regulator_enable_next = ext_req
        | trst_req
        | fabric_req
        | (supply_rise & (regulator_initial_state == INIT_STATE_ON))
        | init_req_reg
        | match_rise
        | wake_q;
    end
    // core counts as good once the regulator has been on for a cycle
    core_good_next = regulator_enable_reg & regulator_enable_next;
    core_powerup_next = ~ext_level;
  end

  // output registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regulator_enable_reg <= REG_ENABLE_RST;
      core_good_reg <= CORE_GOOD_RST;
      core_powerup_reg <= CORE_PWRUP_RST;
    end else begin
      regulator_enable_reg <= regulator_enable_next;
      core_good_reg <= core_good_next;
      core_powerup_reg <= core_powerup_next;
    end
  end

  assign regulator_enable = regulator_enable_reg;
  assign core_good = core_good_reg;
  assign core_powerup_out = core_powerup_reg;

  // pin low forces the regulator on next cycle
  ext_pin_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_up && ext_level == 1'b0) |=> regulator_enable)
    else $error("regulator not on with power-up pin low");

  // trst high keeps the regulator on
  trst_keeps_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_up && jtag_trst) [*2] |=> regulator_enable [*1])
    else $error("regulator not on with trst high");

  // fabric low with nothing else active turns it off
  fabric_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ext_level && !jtag_trst && !fabric_powerup_req && !wake_q && !match_rise
     && !init_req_reg && !supply_rise) |=> !regulator_enable)
    else $error("regulator on with no request");

  // fabric high turns it on
  fabric_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_up && fabric_powerup_req) |=> regulator_enable)
    else $error("regulator off with fabric request high");

  // initial state bit at supply arrival
  init_state_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_rise && regulator_initial_state) |=> (regulator_enable && init_req_reg))
    else $error("regulator not enabled by initial state");

  // match rising edge turns the regulator on and latches
  match_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_up && counter_match_wake && !$past(counter_match_wake))
      |=> (regulator_enable && wake_q))
    else $error("match edge did not wake regulator");

  // core good only after the regulator has been on two cycles
  core_good_a: assert property (@(posedge ref_clk) disable iff (reset)
    core_good |-> (regulator_enable && $past(regulator_enable)))
    else $error("core good without powered core");

  // core power-up output mirrors the inverted pin
  core_pwrup_a: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> (core_powerup_out == !$past(ext_level)))
    else $error("core power-up output not inverse of pin");

  // no supply means regulator off
  no_supply_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    !supply_up |=> (!regulator_enable && !core_good [*1]))
    else $error("regulator on without supply");

  // undriven pin reads high
  pin_pullup_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ext_powerup_oe |-> ##1 !core_powerup_out)
    else $error("undriven pin did not read high");

  // latched wake with supply present keeps the regulator on next cycle
  wake_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_up && wake_q) |=> regulator_enable)
    else $error("wake latch set but regulator off");

  // fabric request falling clears the latched wake unless a new edge arrives
  wake_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wake_q && supply_up && $past(fabric_powerup_req) && !fabric_powerup_req && !match_rise)
      |=> !wake_q)
    else $error("wake latch not cleared by fabric request fall");

  // supply loss drops both latched requests unless a match edge arrives
  supply_loss_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!supply_up && !match_rise) |=> (!wake_q && !init_req_reg))
    else $error("latched request kept without supply");

  // initial state bit at zero leaves no request at supply arrival
  init_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_rise && !regulator_initial_state) |=> !init_req_reg)
    else $error("initial state zero still requested power-up");

  // a steady request keeps the core reported good
  core_good_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    (regulator_enable && supply_up && jtag_trst) |=> core_good)
    else $error("core good low with regulator held on");

  // a driven-low pin shows as core power-up next cycle
  pin_drive_pwrup_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ext_powerup_oe && !ext_powerup_n) |=> core_powerup_out)
    else $error("core power-up output low with pin driven low");

endmodule

// file: crpc_far_side.sv
// far-side model: power-up pin driver, jtag reset and counter match
`timescale 1ns/1ps
module crpc_far_side (
  input wire logic ref_clk,
  output logic ext_powerup_n,
  output logic ext_powerup_oe,
  output logic jtag_trst,
  output logic counter_match_wake
);
  initial begin
    ext_powerup_n = 1'b1;
    ext_powerup_oe = 1'b0;
    jtag_trst = 1'b0;
    counter_match_wake = 1'b0;
  end
  // new pin, test reset and match levels
  task drive(input logic oe, input logic n, input logic trst, input logic match);
    ext_powerup_oe = oe;
    // released pin floats up to the pull-up level
    ext_powerup_n = oe ? n : 1'b1;
    jtag_trst = trst;
    counter_match_wake = match;
  endtask
endmodule

// file: crpc_pkg.sv
// shared constants for the core regulator power-up control
package crpc_pkg;
  // reset values of the registered outputs and internal state
  localparam logic REG_ENABLE_RST = 1'b0;
  localparam logic CORE_GOOD_RST = 1'b0;
  localparam logic CORE_PWRUP_RST = 1'b0;
  localparam logic SUPPLY_PREV_RST = 1'b0;
  localparam logic FABRIC_PREV_RST = 1'b0;
  localparam logic INIT_REQ_RST = 1'b0;
  localparam logic WAKE_LATCH_RST = 1'b0;
  localparam logic MATCH_PREV_RST = 1'b0;
  // level that the weak pull-up gives an undriven power-up pin
  localparam logic PIN_PULLUP_LEVEL = 1'b1;
  // active levels of the power-up requests
  localparam logic EXT_PWRUP_ACTIVE = 1'b0;
  localparam logic TRST_PWRUP_ACTIVE = 1'b1;
  localparam logic FABRIC_PWRUP_ACTIVE = 1'b1;
  localparam logic INIT_STATE_ON = 1'b1;
endpackage

// file: crpc_wake_latch.sv
// rising-edge catcher that holds a wake request until cleared
`timescale 1ns/1ps
module crpc_wake_latch
  import crpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic match_in,
  input wire logic clear,
  output logic rise,
  output logic wake_q
);

  logic match_prev_reg;
  logic match_prev_next;
  logic wake_reg;
  logic wake_next;

  // edge detect and latch; a set in the clear cycle wins
  always_comb begin
    match_prev_next = match_in;
    rise = match_in & ~match_prev_reg;
    if (rise) begin
      wake_next = 1'b1;
    end else if (clear) begin
      wake_next = 1'b0;
    end else begin
      wake_next = wake_reg;
    end
  end

  // state registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      match_prev_reg <= MATCH_PREV_RST;
      wake_reg <= WAKE_LATCH_RST;
    end else begin
      match_prev_reg <= match_prev_next;
      wake_reg <= wake_next;
    end
  end

  assign wake_q = wake_reg;

endmodule

// file: tb_crpc_core_regulator_powerup_control.sv
// testbench for the core regulator power-up control
`timescale 1ns/1ps
module tb_crpc_core_regulator_powerup_control;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic fabric_powerup_req = 1'b0;
  logic regulator_initial_state = 1'b0;
  logic supply_up = 1'b0;
  logic ext_powerup_n, ext_powerup_oe, jtag_trst, counter_match_wake;
  logic regulator_enable, core_powerup_out, core_good;
  logic [2:0] exp_q[$];
  logic [2:0] e;
  // reference state, starts at reset values
  logic s_prev = 1'b0, f_prev = 1'b0, m_prev = 1'b0;
  logic wake = 1'b0, init = 1'b0, en_prev = 1'b0;
  int miscompares = 0;
  int n_compared = 0;

  crpc_far_side crpc_far_side_i (
    .ref_clk(ref_clk),
    .ext_powerup_n(ext_powerup_n),
    .ext_powerup_oe(ext_powerup_oe),
    .jtag_trst(jtag_trst),
    .counter_match_wake(counter_match_wake)
  );
  crpc_core_regulator_powerup_control crpc_core_regulator_powerup_control_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .ext_powerup_n(ext_powerup_n),
    .ext_powerup_oe(ext_powerup_oe),
    .jtag_trst(jtag_trst),
    .fabric_powerup_req(fabric_powerup_req),
    .regulator_initial_state(regulator_initial_state),
    .counter_match_wake(counter_match_wake),
    .supply_up(supply_up),
    .regulator_enable(regulator_enable),
    .core_powerup_out(core_powerup_out),
    .core_good(core_good)
  );

  // clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // one cycle of inputs {sup,init,fab,oe,n,trst,match}, expected outputs queued
  task step(input logic [6:0] v);
    logic pin_low, en, clr, rise, son;
    @(negedge ref_clk);
    {supply_up, regulator_initial_state, fabric_powerup_req} = v[6:4];
    crpc_far_side_i.drive(v[3], v[2], v[1], v[0]);
    pin_low = v[3] & ~v[2];
    // latched requests clear on fabric fall or supply loss; new edges win
    clr = (f_prev & ~v[4]) | ~v[6];
    rise = v[0] & ~m_prev;
    son = v[6] & v[5] & ~s_prev;
    // enable sees the latches as they stood before this cycle's clear
    en = v[6] & (pin_low | v[1] | v[4] | rise | son | wake | init);
    wake = rise | (wake & ~clr);
    init = son | (init & ~clr);
    exp_q.push_back({en, pin_low, en & en_prev});
    {s_prev, f_prev, m_prev, en_prev} = {v[6], v[4], v[0], en};
  endtask

  task run(input logic [6:0] v, input int n);
    repeat (n) step(v);
  endtask

  task chk(input string what, input logic ex, input logic got);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, ex, got);
    end
  endtask

  // output watcher, settled 1 ns after each edge
  always @(posedge ref_clk) begin
    #1;
    if (!reset && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("regulator_enable", e[2], regulator_enable);
      chk("core_powerup_out", e[1], core_powerup_out);
      chk("core_good", e[0], core_good);
    end
  end

  task summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the ~350 cycles the tests take
  initial begin
    #(20 * 3000);
    miscompares++;
    summarize();
  end

  // tests
  initial begin
    void'($urandom(76));
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    run(7'b0100000, 2);
    run(7'b1100000, 3);
    run(7'b1010000, 2);
    run(7'b1000000, 2);
    run(7'b0000000, 2);
    run(7'b1000000, 3);
    $display("test initial state done");
    run(7'b1000001, 2);
    run(7'b1000000, 3);
    run(7'b1010000, 1);
    run(7'b1000000, 2);
    $display("test match wake done");
    run(7'b1001100, 2);
    run(7'b1001000, 3);
    run(7'b0001000, 2);
    run(7'b1000000, 3);
    $display("test power-up pin done");
    run(7'b1000010, 3);
    run(7'b1001110, 2);
    run(7'b1000000, 2);
    $display("test test reset done");
    repeat (300) step({1'($urandom_range(9) != 0), 6'($urandom)});
    $display("test random done");
    run(7'b0000000, 2);
    // let the watcher take the last note
    @(negedge ref_clk);
    summarize();
  end
endmodule
